// ### src/hs_i2c_pkg.sv
package hs_i2c_pkg;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 7;
  localparam logic [7:0] MASTER_CODE_VAL = 8'h08;
  localparam logic [7:0] MASTER_CODE_MASK = 8'hF8;
  localparam int CONT_BIT = 7;
  localparam int DC_BIT = 6;
  localparam int RW_BIT = 0;
  localparam logic [6:0] OWN_ADDR_DEFAULT = 7'h3C;
  localparam int HOST_CLK_DIV = 4;

  function automatic logic is_master_code(input logic [7:0] b);
    return (b & MASTER_CODE_MASK) == MASTER_CODE_VAL;
  endfunction
endpackage

// ### src/hs_i2c_if.sv
`timescale 1ns/1ps
interface hs_i2c_if;
  logic scl_o;
  logic scl_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic hs_serial_clock_pin;
  logic hs_serial_data_pin;

  assign hs_serial_clock_pin = scl_oe ? scl_o : 1'b1;
  assign hs_serial_data_pin = (sda_dev_oe && !sda_dev_o) || (sda_host_oe && !sda_host_o) ? 1'b0 : 1'b1;

  modport device (
    input hs_serial_clock_pin,
    input hs_serial_data_pin,
    output sda_dev_o,
    output sda_dev_oe
  );
  modport host (
    input hs_serial_clock_pin,
    input hs_serial_data_pin,
    output scl_o,
    output scl_oe,
    output sda_host_o,
    output sda_host_oe
  );
endinterface

// ### src/hs_i2c_slave_command_port.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Data change while clock high is control.
// - Detect start and stop conditions.
// - Master starts only on idle bus.
// - Each byte has one acknowledge slot.
// - Receiver slave pulls ack low.
// - Master acks reads, nacks final byte.
// - On master nack, release data line.
// - Hs mode after start, master code, nack.
// - Never acknowledge the master code.
// - Master sends repeated start then address.
// - Hs mode held until stop.
// - Ack own address, ignore others.
// - Parse and ack control/data pairs.
// - Continuation zero means data stream follows.
// - Continuation one expects another control byte.
// - Select zero write goes to decoder.
// - Select zero read returns status.
// - Select one write stores RAM, advances.
// - Select one read returns no RAM.
// - Read sends bytes until master nack.
// - Master sets select by preceding write.
// - Master chains transfers, stop leaves Hs.
// - Select is control byte bit six.
module hs_i2c_slave_command_port
  import hs_i2c_pkg::*;
#(
  parameter logic [ADDR_W-1:0] OWN_ADDR = OWN_ADDR_DEFAULT
) (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  hs_i2c_if.device bus,
  input wire logic [BYTE_W-1:0] i_status_byte,
  output logic o_cmd_strobe,
  output logic [BYTE_W-1:0] o_cmd_byte,
  output logic o_ram_strobe,
  output logic [BYTE_W-1:0] o_ram_byte,
  output logic o_ram_ptr_inc,
  output logic o_hs_mode,
  output logic o_acknowledge_output_pin
);

  // ****************************************************************
  // Pin synchronisers and edge detection.
  // ****************************************************************
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic scl_prev_q;
  logic sda_prev_q;

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], bus.hs_serial_clock_pin};
      sda_sync_q <= {sda_sync_q[0], bus.hs_serial_data_pin};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  wire logic scl = scl_sync_q[1];
  wire logic sda = sda_sync_q[1];
  wire logic scl_rise = scl && !scl_prev_q;
  wire logic scl_fall = !scl && scl_prev_q;
  // A data edge only counts while the clock was already high on both samples.
  wire logic start_det = scl && scl_prev_q && sda_prev_q && !sda;
  wire logic stop_det = scl && scl_prev_q && !sda_prev_q && sda;

  // ****************************************************************
  // Byte framing.
  // ****************************************************************
  typedef enum {ST_IDLE, ST_MCODE, ST_ADDR, ST_CTRL, ST_DATA, ST_READ, ST_SKIP} phase_t;
  phase_t phase_q;
  logic [3:0] bit_cnt_q;
  logic [BYTE_W-1:0] shift_q;
  logic ack_slot_q;
  logic drive_low_q;
  logic hs_q;
  logic first_byte_q;
  logic cont_q;
  logic dc_q;
  logic master_nack_q;

  wire logic byte_done = scl_rise && bit_cnt_q == 4'd7 && !ack_slot_q;
  wire logic [BYTE_W-1:0] rx_byte = {shift_q[BYTE_W-2:0], sda};

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      phase_q <= ST_IDLE;
      bit_cnt_q <= 4'd0;
      shift_q <= 8'h00;
      ack_slot_q <= 1'b0;
      drive_low_q <= 1'b0;
      hs_q <= 1'b0;
      first_byte_q <= 1'b0;
      cont_q <= 1'b1;
      dc_q <= 1'b0;
      master_nack_q <= 1'b0;
    end else if (stop_det) begin
      phase_q <= ST_IDLE;
      hs_q <= 1'b0;
      drive_low_q <= 1'b0;
      ack_slot_q <= 1'b0;
    end else if (start_det) begin
      // Hs mode survives repeated starts, so the next byte is an address.
      phase_q <= hs_q ? ST_ADDR : ST_MCODE;
      bit_cnt_q <= 4'd0;
      ack_slot_q <= 1'b0;
      drive_low_q <= 1'b0;
    end else if (phase_q != ST_IDLE) begin
      if (byte_done) begin
        ack_slot_q <= 1'b1;
        shift_q <= rx_byte;
      end else if (scl_rise && !ack_slot_q && phase_q != ST_READ) begin
        shift_q <= rx_byte;
        bit_cnt_q <= bit_cnt_q + 4'd1;
      end else if (scl_rise && !ack_slot_q) begin
        bit_cnt_q <= bit_cnt_q + 4'd1;
      end
      if (scl_rise && ack_slot_q && phase_q == ST_READ) begin
        master_nack_q <= sda;
      end
      // Falling edge after the eighth bit: decide the acknowledge slot.
      if (scl_fall && ack_slot_q && !drive_low_q && bit_cnt_q == 4'd7) begin
        bit_cnt_q <= 4'd8;
        case (phase_q)
          ST_MCODE: begin
            hs_q <= is_master_code(shift_q);
            phase_q <= ST_SKIP;
          end
          ST_ADDR: begin
            if (shift_q[BYTE_W-1:1] == OWN_ADDR) begin
              drive_low_q <= 1'b1;
              phase_q <= shift_q[RW_BIT] ? ST_READ : ST_CTRL;
              first_byte_q <= 1'b1;
              cont_q <= 1'b1;
            end else begin
              phase_q <= ST_SKIP;
            end
          end
          ST_CTRL: begin
            drive_low_q <= 1'b1;
            cont_q <= shift_q[CONT_BIT];
            dc_q <= shift_q[DC_BIT];
            phase_q <= ST_DATA;
          end
          ST_DATA: begin
            drive_low_q <= 1'b1;
            phase_q <= cont_q ? ST_CTRL : ST_DATA;
          end
          ST_READ: begin
            // The master acknowledges a read byte, not us.
          end
          default: begin
            phase_q <= ST_SKIP;
          end
        endcase
      end else if (scl_fall && ack_slot_q && bit_cnt_q == 4'd8) begin
        // End of the acknowledge slot.
        ack_slot_q <= 1'b0;
        drive_low_q <= 1'b0;
        bit_cnt_q <= 4'd0;
        first_byte_q <= 1'b0;
        if (phase_q == ST_READ && master_nack_q) begin
          phase_q <= ST_SKIP;
        end
      end
    end
  end

  // ****************************************************************
  // Read shifter and data line drive.
  // ****************************************************************
  logic [BYTE_W-1:0] tx_q;
  logic tx_low_q;

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_q <= 8'hFF;
      tx_low_q <= 1'b0;
    end else if (phase_q != ST_READ || stop_det || start_det) begin
      tx_q <= 8'hFF;
      tx_low_q <= 1'b0;
    end else if (scl_fall && bit_cnt_q == 4'd8 && ack_slot_q && !master_nack_q) begin
      // Selecting RAM for a read yields all ones, never RAM contents.
      tx_q <= dc_q ? 8'hFF : i_status_byte;
      tx_low_q <= dc_q ? 1'b0 : !i_status_byte[BYTE_W-1];
    end else if (scl_fall && bit_cnt_q <= 4'd7 && !ack_slot_q) begin
      // The fall after the seventh bit must still shift out the last data bit.
      tx_q <= {tx_q[BYTE_W-2:0], 1'b1};
      tx_low_q <= !tx_q[BYTE_W-2];
    end else if (scl_fall && bit_cnt_q == 4'd7 && ack_slot_q) begin
      tx_low_q <= 1'b0;
    end
  end

  // First read byte is loaded as soon as the address acknowledge ends.
  wire logic read_enter = phase_q == ST_READ && first_byte_q;

  assign bus.sda_dev_o = 1'b0;
  assign bus.sda_dev_oe = drive_low_q || (tx_low_q && !read_enter) ||
                          (read_enter && !ack_slot_q && !dc_q && !i_status_byte[BYTE_W-1] && bit_cnt_q == 4'd0);

  // ****************************************************************
  // Strobes toward decoder and display RAM.
  // ****************************************************************
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_cmd_strobe <= 1'b0;
      o_cmd_byte <= 8'h00;
      o_ram_strobe <= 1'b0;
      o_ram_byte <= 8'h00;
      o_ram_ptr_inc <= 1'b0;
    end else begin
      o_cmd_strobe <= 1'b0;
      o_ram_strobe <= 1'b0;
      o_ram_ptr_inc <= 1'b0;
      if (scl_fall && ack_slot_q && !drive_low_q && bit_cnt_q == 4'd7 && phase_q == ST_DATA) begin
        if (dc_q) begin
          o_ram_strobe <= 1'b1;
          o_ram_byte <= shift_q;
          o_ram_ptr_inc <= 1'b1;
        end else begin
          o_cmd_strobe <= 1'b1;
          o_cmd_byte <= shift_q;
        end
      end
    end
  end

  assign o_hs_mode = hs_q;
  assign o_acknowledge_output_pin = bus.sda_dev_oe;

endmodule

// ### src/hs_i2c_master_end.sv
`timescale 1ns/1ps
module hs_i2c_master_end
  import hs_i2c_pkg::*;
#(
  parameter int CLK_DIV = HOST_CLK_DIV
) (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  hs_i2c_if.host bus,
  input wire logic i_req,
  input wire logic [2:0] i_op,
  input wire logic [BYTE_W-1:0] i_wdata,
  input wire logic i_rack,
  output logic o_ready,
  output logic o_done,
  output logic [BYTE_W-1:0] o_rdata,
  output logic o_ack_seen
);
  // Operation codes: 0 start, 1 write byte, 2 read byte, 3 stop.
  // The divider counter is eight bits wide, which caps the division.
  if (CLK_DIV < 2 || CLK_DIV > 256) begin : g_bad_clk_div
    $error("CLK_DIV must lie between 2 and 256");
  end

  typedef enum {M_IDLE, M_START, M_BIT, M_STOP} mstate_t;
  mstate_t st_q;
  logic [7:0] div_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [8:0] sh_q;
  logic rd_q;
  logic [1:0] sda_sync_q;
  logic [1:0] scl_sync_q;

  wire logic tick = div_q == 8'(CLK_DIV - 1);
  wire logic bus_idle = scl_sync_q[1] && sda_sync_q[1];

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sda_sync_q <= 2'h3;
      scl_sync_q <= 2'h3;
    end else begin
      sda_sync_q <= {sda_sync_q[0], bus.hs_serial_data_pin};
      scl_sync_q <= {scl_sync_q[0], bus.hs_serial_clock_pin};
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_q <= 8'h00;
    end else begin
      div_q <= tick ? 8'h00 : div_q + 8'h01;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q <= M_IDLE;
      ph_q <= 2'd0;
      bit_q <= 4'd0;
      sh_q <= 9'h1FF;
      rd_q <= 1'b0;
      o_done <= 1'b0;
      o_rdata <= 8'h00;
      o_ack_seen <= 1'b0;
      bus.scl_o <= 1'b1;
      bus.sda_host_o <= 1'b1;
    end else begin
      o_done <= 1'b0;
      case (st_q)
        M_IDLE: begin
          if (i_req) begin
            ph_q <= 2'd0;
            bit_q <= 4'd0;
            rd_q <= i_op == 3'd2;
            sh_q <= (i_op == 3'd2) ? {8'hFF, !i_rack} : {i_wdata, 1'b1};
            // A fresh start needs an idle bus; a repeated start is ours.
            if (i_op == 3'd0 && (bus_idle || !bus.scl_o)) st_q <= M_START;
            else if (i_op == 3'd3) st_q <= M_STOP;
            else if (i_op == 3'd1 || i_op == 3'd2) st_q <= M_BIT;
          end
        end
        M_START: if (tick) begin
          ph_q <= ph_q + 2'd1;
          case (ph_q)
            2'd0: bus.sda_host_o <= 1'b1;
            2'd1: bus.scl_o <= 1'b1;
            2'd2: bus.sda_host_o <= 1'b0;
            default: begin
              bus.scl_o <= 1'b0;
              st_q <= M_IDLE;
              o_done <= 1'b1;
            end
          endcase
        end
        M_BIT: if (tick) begin
          ph_q <= ph_q + 2'd1;
          case (ph_q)
            2'd0: bus.sda_host_o <= sh_q[8];
            2'd1: bus.scl_o <= 1'b1;
            2'd2: begin
              sh_q <= {sh_q[7:0], sda_sync_q[1]};
            end
            default: begin
              bus.scl_o <= 1'b0;
              bit_q <= bit_q + 4'd1;
              if (bit_q == 4'd8) begin
                st_q <= M_IDLE;
                o_done <= 1'b1;
                o_rdata <= sh_q[8:1];
                o_ack_seen <= !sh_q[0];
                bus.sda_host_o <= 1'b1;
              end
            end
          endcase
        end
        M_STOP: if (tick) begin
          ph_q <= ph_q + 2'd1;
          case (ph_q)
            2'd0: bus.sda_host_o <= 1'b0;
            2'd1: bus.scl_o <= 1'b1;
            2'd2: bus.sda_host_o <= 1'b1;
            default: begin
              st_q <= M_IDLE;
              o_done <= 1'b1;
            end
          endcase
        end
        default: st_q <= M_IDLE;
      endcase
    end
  end

  // In read bits the host releases the line; in the ack slot it drives the inverse of i_rack.
  wire logic host_reads = rd_q && st_q == M_BIT && bit_q < 4'd8;
  assign bus.scl_oe = 1'b1;
  assign bus.sda_host_oe = !host_reads && !bus.sda_host_o;
  assign o_ready = st_q == M_IDLE;
endmodule

// ### tb/hs_i2c_properties.sv
`timescale 1ns/1ps
module hs_i2c_properties (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic hs_serial_clock_pin,
  input wire logic hs_serial_data_pin,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe
);
  logic scl_q, sda_q, idle_q, mc_q, start, stop, rise, ack_slot;
  logic [3:0] bits_q;
  assign start = scl_q && hs_serial_clock_pin && sda_q && !hs_serial_data_pin;
  assign stop = scl_q && hs_serial_clock_pin && !sda_q && hs_serial_data_pin;
  assign rise = !scl_q && hs_serial_clock_pin;
  assign ack_slot = mc_q && rise && bits_q == 4'h8;
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
    end else begin
      scl_q <= hs_serial_clock_pin;
      sda_q <= hs_serial_data_pin;
    end
  end
  // ********************************
  // Tracks the first byte after an idle bus, which can only be a master code.
  // ********************************
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      idle_q <= 1'h1;
      mc_q <= 1'h0;
      bits_q <= 4'h0;
    end else begin
      idle_q <= stop ? 1'h1 : (start ? 1'h0 : idle_q);
      mc_q <= start ? idle_q : (ack_slot ? 1'h0 : mc_q);
      bits_q <= start ? 4'h0 : (rise ? bits_q + 4'h1 : bits_q);
    end
  end
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_arst_n);
  sequence s_high_end;
    ##[1:12] !hs_serial_clock_pin;
  endsequence
  property p_dev_open_drain;
    sda_dev_oe |-> !sda_dev_o;
  endproperty
  property p_change_low;
    $changed(sda_dev_oe) |-> !hs_serial_clock_pin;
  endproperty
  property p_ack_hold;
    $rose(hs_serial_clock_pin) && sda_dev_oe |-> sda_dev_oe throughout s_high_end;
  endproperty
  property p_mc_no_ack;
    ack_slot |-> !sda_dev_oe;
  endproperty
  property p_mc_nack;
    ack_slot |-> hs_serial_data_pin;
  endproperty
  property p_start_free;
    $fell(hs_serial_data_pin) && hs_serial_clock_pin |-> !sda_dev_oe;
  endproperty
  property p_quiet_stop;
    stop |-> (!sda_dev_oe) [*8];
  endproperty
  property p_scl_high_bounded;
    rise |-> ##[1:40] (!hs_serial_clock_pin || stop);
  endproperty
  a_dev_open_drain: assert property (p_dev_open_drain) else $error("device drives data high");
  a_change_low: assert property (p_change_low) else $error("device data changed with clock high");
  a_ack_hold: assert property (p_ack_hold) else $error("device released data in clock high");
  a_mc_no_ack: assert property (p_mc_no_ack) else $error("device acked the master code");
  a_mc_nack: assert property (p_mc_nack) else $error("master code slot not high");
  a_start_free: assert property (p_start_free) else $error("device held data at start");
  a_quiet_stop: assert property (p_quiet_stop) else $error("device drove data after stop");
  a_scl_high_bounded: assert property (p_scl_high_bounded) else $error("clock high too long");
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import hs_i2c_pkg::*;
  logic i_clk_sys = 1'h0;
  logic i_arst_n, i_req, i_rack, o_ready, o_done, o_ack_seen, cmd_stb, ram_stb, ram_inc, hs, ack_pin, ack_pin_seen;
  logic [2:0] i_op;
  logic [7:0] i_wdata, o_rdata, cmd_b, ram_b, st, last_cmd, last_ram;
  int fail_count = 0, tests_run = 0, n_cmd = 0, n_ram = 0, n_inc = 0;
  hs_i2c_if bus_if ();
  hs_i2c_slave_command_port hs_i2c_slave_command_port_inst (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
    .bus(bus_if.device), .i_status_byte(st), .o_cmd_strobe(cmd_stb), .o_cmd_byte(cmd_b),
    .o_ram_strobe(ram_stb), .o_ram_byte(ram_b), .o_ram_ptr_inc(ram_inc), .o_hs_mode(hs),
    .o_acknowledge_output_pin(ack_pin));
  hs_i2c_master_end #(.CLK_DIV(2)) hs_i2c_master_end_inst (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
    .bus(bus_if.host), .i_req(i_req), .i_op(i_op), .i_wdata(i_wdata), .i_rack(i_rack), .o_ready(o_ready),
    .o_done(o_done), .o_rdata(o_rdata), .o_ack_seen(o_ack_seen));
  hs_i2c_properties hs_i2c_properties_inst (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
    .hs_serial_clock_pin(bus_if.hs_serial_clock_pin), .hs_serial_data_pin(bus_if.hs_serial_data_pin),
    .sda_dev_o(bus_if.sda_dev_o), .sda_dev_oe(bus_if.sda_dev_oe));
  always #12.5 i_clk_sys = ~i_clk_sys;
  always @(negedge i_clk_sys) begin
    if (cmd_stb === 1'h1) begin
      n_cmd++;
      last_cmd = cmd_b;
    end
    if (ram_stb === 1'h1) begin
      n_ram++;
      last_ram = ram_b;
    end
    if (ram_inc === 1'h1) n_inc++;
    if (ack_pin === 1'h1) ack_pin_seen = 1'h1;
  end
  task end_sim;
    if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk8(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: byte %h expected %h", $time, g, e);
    end
  endtask
  task chk1(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: flag %b expected %b", $time, g, e);
    end
  endtask
  task chk_n(input int g, input int e);
    tests_run++;
    if (g != e) begin
      fail_count++;
      $display("mismatch at %0t: count %0d expected %0d", $time, g, e);
    end
  endtask
  // ********************************
  // Master operations; a hung handshake ends the run as a failure.
  // ********************************
  task op(input logic [2:0] c, input logic [7:0] d, input logic rk);
    int n;
    @(negedge i_clk_sys);
    i_req = 1'h1;
    i_op = c;
    i_wdata = d;
    i_rack = rk;
    for (n = 0; o_ready !== 1'h1 && n < 200; n++) @(negedge i_clk_sys);
    if (n >= 200) begin
      fail_count++;
      $display("mismatch at %0t: master never ready", $time);
      end_sim();
    end
    @(negedge i_clk_sys);
    i_req = 1'h0;
    for (n = 0; o_done !== 1'h1 && n < 400; n++) @(negedge i_clk_sys);
    if (n >= 400) begin
      fail_count++;
      $display("mismatch at %0t: no completion", $time);
      end_sim();
    end
  endtask
  task wr(input logic [7:0] d);
    op(3'h1, d, 1'h0);
  endtask
  task addr(input logic [6:0] a, input logic rw, input logic e);
    op(3'h0, 8'h00, 1'h0);
    ack_pin_seen = 1'h0;
    wr({a, rw});
    chk1(o_ack_seen, e);
    chk1(ack_pin_seen, e);
  endtask
  task hs_enter(input logic [7:0] mc);
    op(3'h0, 8'h00, 1'h0);
    wr(mc);
    chk1(o_ack_seen, 1'h0);
    chk1(hs, 1'h1);
  endtask
  task s_pairs;
    hs_enter(8'h0F);
    addr(OWN_ADDR_DEFAULT, 1'h0, 1'h1);
    wr(8'hC0);
    chk1(o_ack_seen, 1'h1);
    wr(8'hA5);
    chk_n(n_ram, 1);
    chk_n(n_inc, 1);
    chk8(last_ram, 8'hA5);
    wr(8'h80);
    wr(8'h3C);
    chk1(o_ack_seen, 1'h1);
    chk8(last_cmd, 8'h3C);
    wr(8'h00);
    wr(8'hC0);
    chk8(last_cmd, 8'hC0);
    wr(8'h41);
    chk_n(n_cmd, 3);
    addr(OWN_ADDR_DEFAULT, 1'h1, 1'h1);
    chk1(hs, 1'h1);
    op(3'h2, 8'h00, 1'h1);
    chk8(o_rdata, 8'h5A);
    @(negedge i_clk_sys);
    st = 8'h96;
    op(3'h2, 8'h00, 1'h0);
    chk8(o_rdata, 8'h96);
    op(3'h3, 8'h00, 1'h0);
    // The stop reaches the mode flag only through the pin synchronisers.
    repeat (3) @(negedge i_clk_sys);
    chk1(hs, 1'h0);
  endtask
  task s_stream;
    hs_enter(8'h08);
    addr(OWN_ADDR_DEFAULT, 1'h0, 1'h1);
    wr(8'h40);
    wr(8'h11);
    wr(8'h22);
    chk_n(n_ram, 3);
    chk_n(n_inc, 3);
    chk8(last_ram, 8'h22);
    addr(OWN_ADDR_DEFAULT, 1'h1, 1'h1);
    op(3'h2, 8'h00, 1'h0);
    chk8(o_rdata, 8'hFF);
    op(3'h3, 8'h00, 1'h0);
  endtask
  task s_foreign;
    hs_enter(8'h0C);
    addr(OWN_ADDR_DEFAULT ^ 7'h01, 1'h0, 1'h0);
    wr(8'hC0);
    chk1(o_ack_seen, 1'h0);
    wr(8'h55);
    chk_n(n_ram, 3);
    op(3'h3, 8'h00, 1'h0);
    addr(OWN_ADDR_DEFAULT, 1'h0, 1'h0);
    chk1(hs, 1'h0);
    op(3'h3, 8'h00, 1'h0);
    chk_n(n_cmd, 3);
  endtask
  initial begin
    i_arst_n = 1'h0;
    i_req = 1'h0;
    i_op = 3'h0;
    i_wdata = 8'h00;
    i_rack = 1'h0;
    st = 8'h5A;
    repeat (4) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    i_arst_n = 1'h1;
    s_pairs();
    s_stream();
    s_foreign();
    end_sim();
  end
endmodule
